// file: rtl/cache_error_capture_and_reset.sv
// Cache parity error capture, register reset behaviour and progress timeout
// Operation
// - Translation tag valid bits clear on chip reset, survive timeout reset
// - Fault status, address, formatted address lock until address register read
// - Memory-unit control and dcache mode clear on chip reset only
// - Miss file mode clears fully on chip reset, bit 5 on timeout
// - Chip reset disables cycle counter; count and control otherwise undefined
// - L2 control bits 11:0 clear on reset, bit 12 set at power-up
// - L2 error status locks until one software read
// - External interface status locks until two software reads
// - External control clears listed bits; sets 6:4, 15 on chip reset only
// - External config loads 0000000000017441 hex at power-up
// - External cache size, speeds, write-enable take defaults on power-up reset only
// - Progress timer expiry triggers internal timeout reset
// - Timeout reset keeps state and dispatches machine check immediately
// - Icache parity error sets flag, machine check, captures exception address
// - Icache parity error does not flush the icache
// - L2 data parity sets 8-bit field; repeat errors set secondary flag
// - L2 error address holds 32-byte block, bit 4 first octaword
// - L2 tag parity records address 39:4 and command type
// - Dcache data parity sets bank flag, lock, check, quadword address
// - Same-cycle dcache errors set several bits, no secondary flag
// - Dcache tag parity sets flag, hexword address, store sets write flag
`timescale 1ns/100ps
`include "cache_err_params.svh"

module cache_error_capture_and_reset #(
    parameter int TIMEOUT_CYCLES = `PROGRESS_TIMEOUT_CYCLES,
    parameter int XLATE_ENTRIES = 64
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic power_up,
    input wire cache_err_pkg::reg_req_t req,
    output logic [63:0] rdata,
    input wire logic instr_retired,
    input wire logic icache_tag_err,
    input wire logic icache_data_err,
    input wire logic [39:0] icache_err_pc,
    input wire cache_err_pkg::dcache_err_t dc_err,
    input wire cache_err_pkg::l2_err_t l2_err,
    input wire logic ext_err,
    input wire logic [15:0] ext_err_info,
    input wire logic xlate_fill,
    input wire logic [5:0] xlate_fill_idx,
    output logic machine_check,
    output logic timeout_reset,
    output logic [XLATE_ENTRIES-1:0] xlate_valid,
    output logic cycle_count_enable
);

    typedef struct packed {
        logic [XLATE_ENTRIES-1:0] xlate_valid;
        logic [63:0] fault_status;
        logic [63:0] fault_va;
        logic [63:0] formatted_va;
        logic mm_locked;
        logic [63:0] mem_unit_control;
        logic [63:0] dcache_mode;
        logic [63:0] miss_file_mode;
        logic [31:0] cycle_counter;
        logic [63:0] cycle_counter_control;
        logic [63:0] l2_control;
        logic [63:0] l2_status;
        logic [63:0] l2_addr;
        logic l2_locked;
        logic [63:0] ext_control;
        logic [63:0] ext_config;
        logic [63:0] ext_status;
        logic [1:0] ext_lock_reads;
        logic [1:0] icache_status;
        logic [63:0] exception_address;
        logic [4:0] dcache_status;
        logic [31:0] progress;
        logic mcheck;
        logic timeout;
        logic [63:0] rdata;
    } state_t;

    state_t s;
    state_t next_s;
    logic tmo;

    always_comb
    begin
        logic dc_any;
        logic l2_any;
        dc_any = 1'b0;
        l2_any = 1'b0;
        next_s = s;
        next_s.mcheck = 1'b0;
        next_s.timeout = 1'b0;
        next_s.rdata = 64'h0;
        tmo = s.timeout;

        if (xlate_fill)
        begin
            next_s.xlate_valid[xlate_fill_idx] = 1'b1;
        end
        if (s.cycle_counter_control[0])
        begin
            next_s.cycle_counter = s.cycle_counter + 32'h1;
        end

        ////////////////////////////////////////////////////////////////
        // Register reads, with unlock side effects
        if (req.rd)
        begin
            if (req.addr == `OFS_MEM_FAULT_STATUS)
                next_s.rdata = s.fault_status;
            else if (req.addr == `OFS_FAULT_VA)
            begin
                next_s.rdata = s.fault_va;
                next_s.mm_locked = 1'b0;
                next_s.dcache_status[4] = 1'b0;
            end
            else if (req.addr == `OFS_FORMATTED_VA)
                next_s.rdata = s.formatted_va;
            else if (req.addr == `OFS_MEM_UNIT_CONTROL)
                next_s.rdata = s.mem_unit_control;
            else if (req.addr == `OFS_DCACHE_MODE)
                next_s.rdata = s.dcache_mode;
            else if (req.addr == `OFS_MISS_FILE_MODE)
                next_s.rdata = s.miss_file_mode;
            else if (req.addr == `OFS_CYCLE_COUNTER)
                next_s.rdata = {32'h0, s.cycle_counter};
            else if (req.addr == `OFS_CYCLE_COUNTER_CTL)
                next_s.rdata = s.cycle_counter_control;
            else if (req.addr == `OFS_L2_CONTROL)
                next_s.rdata = s.l2_control;
            else if (req.addr == `OFS_L2_ERR_STATUS)
            begin
                next_s.rdata = s.l2_status;
                next_s.l2_locked = 1'b0;
            end
            else if (req.addr == `OFS_L2_ERR_ADDR)
                next_s.rdata = s.l2_addr;
            else if (req.addr == `OFS_EXT_CONTROL)
                next_s.rdata = s.ext_control;
            else if (req.addr == `OFS_EXT_CONFIG)
                next_s.rdata = s.ext_config;
            else if (req.addr == `OFS_EXT_IFACE_STATUS)
            begin
                next_s.rdata = s.ext_status;
                if (s.ext_lock_reads != 2'h0)
                    next_s.ext_lock_reads = s.ext_lock_reads - 2'h1;
            end
            else if (req.addr == `OFS_ICACHE_PARITY)
                next_s.rdata = {62'h0, s.icache_status};
            else if (req.addr == `OFS_DCACHE_PARITY)
                next_s.rdata = {59'h0, s.dcache_status};
            else if (req.addr == `OFS_EXCEPTION_ADDR)
                next_s.rdata = s.exception_address;
            else if (req.addr == `OFS_XLATE_TAG_VALID)
                next_s.rdata = 64'(s.xlate_valid);
            else
                next_s.rdata = 64'h0;
        end

        ////////////////////////////////////////////////////////////////
        // Register writes
        if (req.wr)
        begin
            if (req.addr == `OFS_MEM_UNIT_CONTROL)
                next_s.mem_unit_control = req.wdata;
            else if (req.addr == `OFS_DCACHE_MODE)
                next_s.dcache_mode = req.wdata;
            else if (req.addr == `OFS_MISS_FILE_MODE)
                next_s.miss_file_mode = req.wdata;
            else if (req.addr == `OFS_CYCLE_COUNTER)
                next_s.cycle_counter = req.wdata[31:0];
            else if (req.addr == `OFS_CYCLE_COUNTER_CTL)
                next_s.cycle_counter_control = req.wdata;
            else if (req.addr == `OFS_L2_CONTROL)
                next_s.l2_control = req.wdata;
            else if (req.addr == `OFS_EXT_CONTROL)
                next_s.ext_control = req.wdata;
            else if (req.addr == `OFS_EXT_CONFIG)
                // software sets size and speeds before enabling
                next_s.ext_config = req.wdata;
            else if (req.addr == `OFS_ICACHE_PARITY)
                next_s.icache_status = s.icache_status & ~req.wdata[1:0];
            else if (req.addr == `OFS_DCACHE_PARITY)
                next_s.dcache_status[3:0] = s.dcache_status[3:0] & ~req.wdata[3:0];
            else if (req.addr == `OFS_XLATE_TAG_VALID)
                next_s.xlate_valid = '0;
        end

        ////////////////////////////////////////////////////////////////
        // Error capture; sets win over software clears above
        // flag, trap before execution, faulting PC
        // no flush is ever requested here
        if (icache_tag_err || icache_data_err)
        begin
            next_s.icache_status = next_s.icache_status | {icache_data_err, icache_tag_err};
            next_s.exception_address = {24'h0, icache_err_pc};
            next_s.mcheck = 1'b1;
        end

        dc_any = dc_err.tag0 | dc_err.tag1 | dc_err.data0 | dc_err.data1;
        // Lock state after this cycle's read, so an error at the unlocking read is kept
        if (dc_any)
        begin
            next_s.mcheck = 1'b1;
            if (next_s.mm_locked)
                next_s.fault_status[1] = 1'b1;
            else
            begin
                // several bits in one cycle, no secondary flag
                next_s.dcache_status[3:0] = {dc_err.tag1, dc_err.tag0, dc_err.data1, dc_err.data0};
                next_s.dcache_status[4] = 1'b1;
                next_s.mm_locked = 1'b1;
                // hexword address for tags, quadword for data
                if (dc_err.tag0 | dc_err.tag1)
                    next_s.fault_va = {24'h0, dc_err.va[39:5], 5'h0};
                else
                    next_s.fault_va = {24'h0, dc_err.va[39:3], 3'h0};
                next_s.fault_status = {62'h0, 1'b0, dc_err.store};
                next_s.formatted_va = {27'h0, dc_err.va[39:3]};
            end
        end

        l2_any = l2_err.tag_err | l2_err.data_err;
        if (l2_any)
        begin
            next_s.mcheck = 1'b1;
            if (next_s.l2_locked)
                next_s.l2_status[15] = 1'b1;
            else
            begin
                next_s.l2_locked = 1'b1;
                // data parity field / command type
                next_s.l2_status = {48'h0, 1'b0, l2_err.cmd, l2_err.tag_par, l2_err.data_par};
                next_s.l2_addr = {24'h0, l2_err.pa[39:4], 4'h0};
            end
        end

        if (ext_err)
        begin
            next_s.mcheck = 1'b1;
            if (next_s.ext_lock_reads != 2'h0)
                next_s.ext_status[63] = 1'b1;
            else
            begin
                next_s.ext_status = {48'h0, ext_err_info};
                next_s.ext_lock_reads = 2'h2;
            end
        end

        ////////////////////////////////////////////////////////////////
        // progress timer
        if (instr_retired || s.timeout)
            next_s.progress = 32'h0;
        else if (s.progress >= 32'(TIMEOUT_CYCLES - 1))
        begin
            next_s.progress = 32'h0;
            next_s.timeout = 1'b1;
        end
        else
            next_s.progress = s.progress + 32'h1;

        // timeout: only listed exceptions change, trap now
        if (s.timeout)
        begin
            next_s.miss_file_mode[`MISS_FILE_TIMEOUT_BIT] = 1'b0;
            // low bits clear on any reset
            next_s.l2_control = next_s.l2_control & ~`L2_CTL_CLEAR_MASK;
            next_s.ext_control = next_s.ext_control & ~`EXT_CTL_CLEAR_MASK;
            next_s.mcheck = 1'b1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            s <= next_s;
            s.xlate_valid <= '0;
            s.mem_unit_control <= 64'h0;
            s.dcache_mode <= 64'h0;
            s.miss_file_mode <= 64'h0;
            s.cycle_counter_control[0] <= 1'b0;
            // clear low field, power-up sets bit 12
            s.l2_control <= (s.l2_control & ~`L2_CTL_CLEAR_MASK) | (power_up ? `L2_CTL_POWERUP_SET : 64'h0);
            s.ext_control <= (s.ext_control & ~`EXT_CTL_CLEAR_MASK) | `EXT_CTL_CHIP_SET;
            if (power_up)
                s.ext_config <= `EXT_CONFIG_POWERUP;
            s.mm_locked <= 1'b0;
            s.l2_locked <= 1'b0;
            s.ext_lock_reads <= 2'h0;
            s.icache_status <= 2'h0;
            s.dcache_status <= 5'h0;
            s.progress <= 32'h0;
            s.mcheck <= 1'b0;
            s.timeout <= 1'b0;
            s.rdata <= 64'h0;
        end
        else
            s <= next_s;
    end

    assign rdata = s.rdata;
    assign machine_check = s.mcheck;
    assign timeout_reset = s.timeout;
    assign xlate_valid = s.xlate_valid;
    assign cycle_count_enable = s.cycle_counter_control[0];

    ////////////////////////////////////////////////////////////////
    // Checks
    chk_xlate_keep_timeout: assert property (@(posedge clock) disable iff (rst)
        tmo |=> (xlate_valid & $past(xlate_valid)) == $past(xlate_valid))
        else $error("translation valid lost on timeout");
    chk_timeout_dispatch: assert property (@(posedge clock) disable iff (rst)
        timeout_reset |=> machine_check)
        else $error("timeout without machine check");
    chk_l2_unlock_read: assert property (@(posedge clock) disable iff (rst)
        (req.rd && req.addr == `OFS_L2_ERR_STATUS && !l2_err.tag_err && !l2_err.data_err) |=> !s.l2_locked)
        else $error("l2 status stays locked after read");
    chk_ext_two_reads: assert property (@(posedge clock) disable iff (rst)
        (s.ext_lock_reads == 2'h2 && req.rd && req.addr == `OFS_EXT_IFACE_STATUS) |=> s.ext_lock_reads != 2'h0)
        else $error("ext status unlocked after one read");
    chk_mm_lock_hold: assert property (@(posedge clock) disable iff (rst)
        (s.mm_locked && !(req.rd && req.addr == `OFS_FAULT_VA) && !(req.wr)) |=> $stable(s.fault_va))
        else $error("locked fault address changed");
    chk_dc_no_secondary: assert property (@(posedge clock) disable iff (rst)
        (!s.mm_locked && $countones({dc_err.tag0, dc_err.tag1, dc_err.data0, dc_err.data1}) > 1)
            |=> !s.fault_status[1] && $countones(s.dcache_status[3:0]) > 1)
        else $error("same-cycle dcache errors mishandled");
    chk_icache_check: assert property (@(posedge clock) disable iff (rst)
        icache_data_err |=> machine_check && s.icache_status[1])
        else $error("icache parity not trapped");
    chk_miss_bit5_timeout: assert property (@(posedge clock) disable iff (rst)
        (tmo && !req.wr) |=> !s.miss_file_mode[5] && s.miss_file_mode[4:0] == $past(s.miss_file_mode[4:0]))
        else $error("miss file mode timeout wrong");
    chk_l2_lock_hold: assert property (@(posedge clock) disable iff (rst)
        (s.l2_locked && !(req.rd && req.addr == `OFS_L2_ERR_STATUS))
            |=> $stable(s.l2_addr) && $stable(s.l2_status[14:0]))
        else $error("locked l2 capture overwritten");
    chk_ext_lock_hold: assert property (@(posedge clock) disable iff (rst)
        (s.ext_lock_reads != 2'h0 && !(req.rd && req.addr == `OFS_EXT_IFACE_STATUS))
            |=> $stable(s.ext_status[62:0]))
        else $error("locked ext capture overwritten");
    // Reset checks run without disable so the reset result itself is seen
    chk_chip_reset_clear: assert property (@(posedge clock)
        rst |=> s.mem_unit_control == 64'h0 && s.dcache_mode == 64'h0 && s.miss_file_mode == 64'h0
            && !cycle_count_enable)
        else $error("chip reset left control state");
    chk_ext_ctl_chip: assert property (@(posedge clock)
        rst |=> (s.ext_control & (`EXT_CTL_CLEAR_MASK | `EXT_CTL_CHIP_SET)) == `EXT_CTL_CHIP_SET)
        else $error("ext control chip reset wrong");
    chk_timeout_keep_ctl: assert property (@(posedge clock) disable iff (rst)
        (tmo && !req.wr) |=> $stable(s.mem_unit_control) && $stable(s.dcache_mode))
        else $error("timeout changed kept control");
    // Timeout pulse is one cycle, then the trap
    sequence stall_expiry;
        timeout_reset;
    endsequence
    sequence trap_dispatch;
        machine_check && !timeout_reset;
    endsequence
    chk_timeout_pulse: assert property (@(posedge clock) disable iff (rst)
        stall_expiry |=> trap_dispatch)
        else $error("timeout pulse or trap wrong");

endmodule : cache_error_capture_and_reset

// file: rtl/cache_err_params.svh
// Register offsets, field positions, reset values and timing counts
`ifndef CACHE_ERR_PARAMS_SVH
`define CACHE_ERR_PARAMS_SVH
`define OFS_MEM_FAULT_STATUS 8'h00
`define OFS_FAULT_VA 8'h01
`define OFS_FORMATTED_VA 8'h02
`define OFS_MEM_UNIT_CONTROL 8'h03
`define OFS_DCACHE_MODE 8'h04
`define OFS_MISS_FILE_MODE 8'h05
`define OFS_CYCLE_COUNTER 8'h06
`define OFS_CYCLE_COUNTER_CTL 8'h07
`define OFS_L2_CONTROL 8'h08
`define OFS_L2_ERR_STATUS 8'h09
`define OFS_L2_ERR_ADDR 8'h0a
`define OFS_EXT_CONTROL 8'h0b
`define OFS_EXT_CONFIG 8'h0c
`define OFS_EXT_IFACE_STATUS 8'h0d
`define OFS_ICACHE_PARITY 8'h0e
`define OFS_DCACHE_PARITY 8'h0f
`define OFS_EXCEPTION_ADDR 8'h10
`define OFS_XLATE_TAG_VALID 8'h11
`define MISS_FILE_TIMEOUT_BIT 5
`define L2_CTL_CLEAR_MASK 64'h0000_0000_0000_0fff
`define L2_CTL_POWERUP_SET 64'h0000_0000_0000_1000
`define EXT_CTL_CLEAR_MASK 64'h0000_0000_0ff9_6083
`define EXT_CTL_CHIP_SET 64'h0000_0000_0000_8070
`define EXT_CONFIG_POWERUP 64'h0000_0000_0001_7441
`define PROGRESS_TIMEOUT_CYCLES 32'd1000000
`endif

// file: rtl/cache_err_pkg.sv
// Types for the cache error capture and reset block
package cache_err_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic [63:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic tag0;
        logic tag1;
        logic data0;
        logic data1;
        logic [39:0] va;
        logic store;
    } dcache_err_t;

    typedef struct packed {
        logic tag_err;
        logic data_err;
        logic [7:0] data_par;
        logic [2:0] tag_par;
        logic [3:0] cmd;
        logic [39:0] pa;
    } l2_err_t;
endpackage : cache_err_pkg

// file: testbench/tb_top.sv
// Self-checking bench for the cache error capture and reset block
`timescale 1ns/100ps
`include "cache_err_params.svh"
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin err_total++; $display("[FAIL] %0t got %h exp %h", $time, (got), (exp)); end end

module tb_top;
    logic clock, rst, power_up, instr_retired, icache_tag_err, icache_data_err, ext_err, xlate_fill;
    logic machine_check, timeout_reset, cycle_count_enable;
    cache_err_pkg::reg_req_t req;
    cache_err_pkg::dcache_err_t dc_err;
    cache_err_pkg::l2_err_t l2_err;
    logic [63:0] rdata, rv, xlate_valid;
    logic [39:0] icache_err_pc, va_cap;
    logic [15:0] ext_err_info;
    logic [5:0] xlate_fill_idx;
    logic [31:0] seed;
    logic [63:0] mdl [0:17];
    int err_total, compares;

    cache_error_capture_and_reset #(.TIMEOUT_CYCLES(50), .XLATE_ENTRIES(64)) DUT (.clock(clock), .rst(rst),
        .power_up(power_up), .req(req), .rdata(rdata), .instr_retired(instr_retired),
        .icache_tag_err(icache_tag_err), .icache_data_err(icache_data_err), .icache_err_pc(icache_err_pc),
        .dc_err(dc_err), .l2_err(l2_err), .ext_err(ext_err), .ext_err_info(ext_err_info),
        .xlate_fill(xlate_fill), .xlate_fill_idx(xlate_fill_idx), .machine_check(machine_check),
        .timeout_reset(timeout_reset), .xlate_valid(xlate_valid), .cycle_count_enable(cycle_count_enable));

    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic wr_reg(input logic [7:0] a, input logic [63:0] d);
        @(posedge clock);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        req.wr <= 1'b0;
        mdl[a[4:0]] = d;
    endtask : wr_reg

    // Read data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clock);
        req <= '{addr: a, wdata: 64'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        req.rd <= 1'b0;
        #1 rv = rdata;
    endtask : rd_reg

    // Error kinds: 0 itag, 1 ddata, 2 dtag+ddata same cycle, 3 l2 data, 4 ext, 5 idata, 6 l2 tag
    task automatic ev(input int k);
        @(posedge clock);
        case (k)
            0: icache_tag_err <= 1'b1;
            1: dc_err.data0 <= 1'b1;
            2: {dc_err.tag0, dc_err.data1} <= 2'b11;
            3: l2_err.data_err <= 1'b1;
            4: ext_err <= 1'b1;
            6: l2_err.tag_err <= 1'b1;
            default: icache_data_err <= 1'b1;
        endcase
        dc_err.va <= 40'({rnd(), rnd()});
        ext_err_info <= 16'(rnd());
        @(posedge clock);
        {icache_tag_err, icache_data_err, ext_err, l2_err.data_err, l2_err.tag_err} <= 5'h0;
        {dc_err.tag0, dc_err.tag1, dc_err.data0, dc_err.data1} <= 4'h0;
        #1 `CHK(machine_check, 1'b1)
    endtask : ev

    task automatic do_reset(input logic pu);
        @(posedge clock);
        // board test-port reset rides on rst; no pin here
        rst <= 1'b1;
        power_up <= pu;
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        power_up <= 1'b0;
        mdl[3] = 64'h0;
        mdl[4] = 64'h0;
        mdl[5] = 64'h0;
        #1 `CHK({machine_check, timeout_reset, rdata}, 66'h0)
        `CHK(xlate_valid, 64'h0)
        `CHK(cycle_count_enable, 1'b0)
    endtask : do_reset

    task automatic chk_ctl(input logic [63:0] ext_set);
        rd_reg(`OFS_L2_CONTROL);
        `CHK(rv & `L2_CTL_CLEAR_MASK, 64'h0)
        rd_reg(`OFS_EXT_CONTROL);
        `CHK(rv & (`EXT_CTL_CLEAR_MASK | ext_set), ext_set)
        for (int i = 3; i < 6; i++)
        begin
            rd_reg(8'(i));
            `CHK(rv, (i == 5) ? mdl[i] & ~(64'h1 << `MISS_FILE_TIMEOUT_BIT) : mdl[i])
        end
    endtask : chk_ctl

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : test_done

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #400000;
        err_total++;
        test_done();
    end

    initial
    begin
        seed = 32'he3a7;
        err_total = 0;
        compares = 0;
        {rst, power_up, instr_retired, icache_tag_err, icache_data_err, ext_err, xlate_fill} = 7'h60;
        req = '0;
        dc_err = '0;
        l2_err = '0;
        icache_err_pc = 40'h0;
        ext_err_info = 16'h0;
        xlate_fill_idx = 6'h0;
        instr_retired = 1'b1;
        do_reset(1'b1);
        rd_reg(`OFS_EXT_CONFIG);
        `CHK(rv, `EXT_CONFIG_POWERUP)
        rd_reg(`OFS_L2_CONTROL);
        `CHK(rv & 64'h1fff, `L2_CTL_POWERUP_SET)
        chk_ctl(`EXT_CTL_CHIP_SET);
        rd_reg(8'h20);
        `CHK(rv, 64'h0)
        wr_reg(`OFS_CYCLE_COUNTER_CTL, 64'h1);
        @(posedge clock);
        #1 `CHK(cycle_count_enable, 1'b1)
        // Icache: both flags, exception address, write-one clear
        icache_err_pc <= {rnd(), 8'h04};
        ev(0);
        ev(5);
        rd_reg(`OFS_EXCEPTION_ADDR);
        `CHK(rv, {24'h0, icache_err_pc})
        rd_reg(`OFS_ICACHE_PARITY);
        `CHK(rv[1:0], 2'b11)
        wr_reg(`OFS_ICACHE_PARITY, 64'h3);
        rd_reg(`OFS_ICACHE_PARITY);
        `CHK(rv[1:0], 2'b00)
        // Dcache: lock, secondary while locked, unlock by address read
        ev(1);
        va_cap = dc_err.va;
        rd_reg(`OFS_DCACHE_PARITY);
        `CHK({rv[4], 3'($countones(rv[3:0]))}, 4'h9)
        ev(1);
        rd_reg(`OFS_MEM_FAULT_STATUS);
        `CHK(rv[1], 1'b1)
        rd_reg(`OFS_FAULT_VA);
        `CHK(rv, {24'h0, va_cap[39:3], 3'h0})
        wr_reg(`OFS_DCACHE_PARITY, 64'hf);
        rd_reg(`OFS_DCACHE_PARITY);
        `CHK(rv[4:0], 5'h00)
        dc_err.store <= 1'b1;
        ev(2);
        rd_reg(`OFS_DCACHE_PARITY);
        `CHK(3'($countones(rv[3:0])), 3'd2)
        rd_reg(`OFS_MEM_FAULT_STATUS);
        `CHK(rv[1:0], 2'b01)
        rd_reg(`OFS_FAULT_VA);
        `CHK(rv, {24'h0, dc_err.va[39:5], 5'h0})
        // L2: one read unlocks
        l2_err.data_par <= 8'ha5;
        ev(3);
        ev(3);
        rd_reg(`OFS_L2_ERR_STATUS);
        `CHK(rv[15:0], 16'h80a5)
        ev(3);
        rd_reg(`OFS_L2_ERR_STATUS);
        `CHK(rv[15], 1'b0)
        l2_err.pa <= 40'({rnd(), rnd()});
        l2_err.cmd <= 4'h3;
        l2_err.tag_par <= 3'h5;
        ev(6);
        rd_reg(`OFS_L2_ERR_ADDR);
        `CHK(rv, {24'h0, l2_err.pa[39:4], 4'h0})
        rd_reg(`OFS_L2_ERR_STATUS);
        `CHK(rv[15:0], 16'h1da5)
        // External: needs two reads to unlock
        ev(4);
        rd_reg(`OFS_EXT_IFACE_STATUS);
        ev(4);
        rd_reg(`OFS_EXT_IFACE_STATUS);
        `CHK(rv[63], 1'b1)
        ev(4);
        rd_reg(`OFS_EXT_IFACE_STATUS);
        `CHK(rv, {48'h0, ext_err_info})
        rd_reg(`OFS_EXT_IFACE_STATUS);
        // Progress timeout keeps state apart from listed bits
        for (int i = 3; i < 6; i++)
            wr_reg(8'(i), {rnd(), rnd()});
        wr_reg(`OFS_EXT_CONTROL, 64'hffff_ffff_ffff_ffff);
        for (int i = 0; i < 2; i++)
        begin
            @(posedge clock);
            xlate_fill <= 1'b1;
            xlate_fill_idx <= i ? 6'd60 : 6'd3;
        end
        @(posedge clock);
        xlate_fill <= 1'b0;
        instr_retired <= 1'b0;
        for (int i = 0; i < 200 && timeout_reset !== 1'b1; i++)
            @(posedge clock) #1;
        `CHK(timeout_reset, 1'b1)
        @(posedge clock);
        instr_retired <= 1'b1;
        // Trap follows the one-cycle timeout pulse
        #1 `CHK({timeout_reset, machine_check}, 2'b01)
        repeat (2) @(posedge clock);
        #1 `CHK({xlate_valid[60], xlate_valid[3]}, 2'b11)
        chk_ctl(64'h0);
        rd_reg(`OFS_EXT_CONTROL);
        `CHK(rv, ~`EXT_CTL_CLEAR_MASK)
        // Chip reset after timeout clears what timeout kept
        do_reset(1'b0);
        chk_ctl(`EXT_CTL_CHIP_SET);
        test_done();
    end
endmodule : tb_top
